//--- src/mdp_pkg.sv
package mdp_pkg;

    // ==========================================================
    // Access kinds and request carrier
    typedef enum logic [1:0] {
        MDP_FETCH,
        MDP_CODE_RD,
        MDP_XDATA_RD,
        MDP_XDATA_WR
    } mdp_kind_t;

    typedef struct packed {
        mdp_kind_t   kind;
        logic        use_ptr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mdp_req_t;

    // ==========================================================
    // Memory map
    localparam logic [15:0] SRAM_TOP   = 16'h03FF;
    localparam int          SRAM_WORDS = 1024;
    localparam int          SRAM_AW    = 10;

    // ==========================================================
    // Special function register addresses, enable bit index, reset and fill values
    localparam logic [7:0] SFR_PORT0  = 8'h80;
    localparam logic [7:0] SFR_PTR0_L = 8'h82;
    localparam logic [7:0] SFR_PTR0_H = 8'h83;
    localparam logic [7:0] SFR_PTR1_L = 8'h84;
    localparam logic [7:0] SFR_PTR1_H = 8'h85;
    localparam logic [7:0] SFR_PTR_SEL = 8'h86;
    localparam logic [7:0] SFR_PORT2  = 8'hA0;
    localparam logic [7:0] SFR_PWR_MGMT = 8'hC4;
    localparam int         PWR_SRAM_EN_BIT = 0;
    localparam logic [7:0] SFR_UNIMPL = 8'hFF;
    localparam logic [7:0] PORT_RST   = 8'hFF;
    localparam logic [7:0] BYTE_ONES  = 8'hFF;
    localparam logic [7:0] BYTE_ZERO  = 8'h00;
    localparam logic [15:0] PTR_RST   = 16'h0000;

    // ==========================================================
    // Instruction and timing
    localparam logic [7:0] OP_PTR_DEC = 8'hA5;
    localparam int         MC_CLKS    = 4;
    localparam logic [1:0] MC_LAST    = 2'(MC_CLKS - 1);
    localparam logic [1:0] ALE_CLKS   = 2'h2;
    localparam logic [3:0] CODE_DATA_MC = 4'h1;
    localparam logic [3:0] MC_ONE     = 4'h1;

endpackage

//--- src/mdp_external_data_move_path.sv
// Contract
// - 1KB on-chip SRAM at 0000H-03FFH, data moves only
// - Enable bit in power register turns SRAM on
// - Reset clears enable; all moves go external
// - Enabled: moves inside 1KB served internally
// - Enabled: moves above 03FFH use ports 0/2
// - Move length two to nine machine cycles; on-chip SRAM moves take one
// - Machine cycle is four clocks
// - Opcode A5H decrements active pointer by one
// - Second 16-bit pointer in two extra bytes
// - Select bit one picks second pointer pair
// - Port 0 strong bus, else open drain
// - Port 2 drives high address during bus
// - Wait enabled: port 4 bit 0 input only
// - Scratchpad and SRAM spaces never overlap
// - Registers direct only, scratchpad both modes
// - Fetch and code reads share 64KB space
// - 64KB external data via data moves only
// - Never fetch code from on-chip SRAM
`timescale 1ns/10ps
module mdp_external_data_move_path (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             req_valid,
    input  wire mdp_pkg::mdp_req_t req,
    output logic                  busy,
    output logic                  resp_valid,
    output logic [7:0]            resp_rdata,
    input  wire logic             op_valid,
    input  wire logic [7:0]       opcode,
    input  wire logic             sfr_wr,
    input  wire logic             sfr_indirect,
    input  wire logic [7:0]       sfr_addr,
    input  wire logic [7:0]       sfr_wdata,
    output logic [7:0]            sfr_rdata,
    input  wire logic [2:0]       stretch,
    input  wire logic             wait_enable,
    input  wire logic [7:0]       p0_in,
    output logic [7:0]            p0_out,
    output logic [7:0]            p0_oe,
    output logic                  p0_strong,
    output logic [7:0]            p2_out,
    output logic [7:0]            p2_oe,
    output logic                  ale,
    output logic                  psen_n,
    output logic                  rd_n,
    output logic                  wr_n,
    input  wire logic             p4_0_in,
    output logic                  p4_0_out,
    output logic                  p4_0_oe,
    output logic                  onchip_sram_enable
);

    // ==========================================================
    // Register access and data pointers
    typedef enum logic [1:0] {S_IDLE, S_ADDR, S_DATA, S_INT} mdp_state_t;

    logic [15:0] data_pointer [2];
    logic        pointer_select;
    logic [7:0]  p0_latch;
    logic [7:0]  p2_latch;
    logic [7:0]  sram [mdp_pkg::SRAM_WORDS];
    wire  logic  sfr_we;
    wire  logic  ptr_dec;
    wire  logic [15:0] act_ptr;
    logic [15:0] next_ptr [2];

    assign sfr_we  = sfr_wr && !sfr_indirect;
    assign ptr_dec = op_valid && opcode == mdp_pkg::OP_PTR_DEC;
    assign act_ptr = data_pointer[pointer_select];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ptr
            wire logic [7:0] lo_a = gi ? mdp_pkg::SFR_PTR1_L
                                       : mdp_pkg::SFR_PTR0_L;
            wire logic [7:0] hi_a = gi ? mdp_pkg::SFR_PTR1_H
                                       : mdp_pkg::SFR_PTR0_H;
            wire logic sel = pointer_select == 1'(gi);
            always_comb begin
                next_ptr[gi] = data_pointer[gi];
                if (sfr_we && sfr_addr == lo_a) begin
                    next_ptr[gi][7:0] = sfr_wdata;
                end
                if (sfr_we && sfr_addr == hi_a) begin
                    next_ptr[gi][15:8] = sfr_wdata;
                end
                if (ptr_dec && sel) begin
                    next_ptr[gi] = data_pointer[gi] - 16'h0001;
                end
            end
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    data_pointer[gi] <= mdp_pkg::PTR_RST;
                end else begin
                    data_pointer[gi] <= next_ptr[gi];
                end
            end
        end
    endgenerate

    wire logic [7:0] next_sfr_rdata =
        sfr_indirect                         ? mdp_pkg::SFR_UNIMPL :
        sfr_addr == mdp_pkg::SFR_PTR0_L      ? data_pointer[0][7:0] :
        sfr_addr == mdp_pkg::SFR_PTR0_H      ? data_pointer[0][15:8] :
        sfr_addr == mdp_pkg::SFR_PTR1_L      ? data_pointer[1][7:0] :
        sfr_addr == mdp_pkg::SFR_PTR1_H      ? data_pointer[1][15:8] :
        sfr_addr == mdp_pkg::SFR_PTR_SEL     ? {7'h00, pointer_select} :
        sfr_addr == mdp_pkg::SFR_PWR_MGMT    ? {7'h00, onchip_sram_enable} :
        sfr_addr == mdp_pkg::SFR_PORT0       ? p0_latch :
        sfr_addr == mdp_pkg::SFR_PORT2       ? p2_latch :
                                               mdp_pkg::SFR_UNIMPL;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pointer_select     <= 1'b0;
            onchip_sram_enable <= 1'b0;
            p0_latch           <= mdp_pkg::PORT_RST;
            p2_latch           <= mdp_pkg::PORT_RST;
            sfr_rdata          <= mdp_pkg::SFR_UNIMPL;
        end else begin
            sfr_rdata <= next_sfr_rdata;
            if (sfr_we && sfr_addr == mdp_pkg::SFR_PTR_SEL) begin
                pointer_select <= sfr_wdata[0];
            end
            if (sfr_we && sfr_addr == mdp_pkg::SFR_PWR_MGMT) begin
                onchip_sram_enable <= sfr_wdata[mdp_pkg::PWR_SRAM_EN_BIT];
            end
            if (sfr_we && sfr_addr == mdp_pkg::SFR_PORT0) begin
                p0_latch <= sfr_wdata;
            end
            if (sfr_we && sfr_addr == mdp_pkg::SFR_PORT2) begin
                p2_latch <= sfr_wdata;
            end
        end
    end

    // ==========================================================
    // Access sequencer
    mdp_state_t        st;
    mdp_state_t        next_st;
    logic [1:0]        ck;
    logic [3:0]        mc;
    mdp_pkg::mdp_req_t cur;

    wire logic take = req_valid && st == S_IDLE;
    wire logic [15:0] eff_addr = req.use_ptr ? act_ptr : req.addr;
    wire logic is_x = req.kind == mdp_pkg::MDP_XDATA_RD
                   || req.kind == mdp_pkg::MDP_XDATA_WR;
    // Code space never maps onto the on-chip SRAM
    wire logic hit_int = is_x && onchip_sram_enable
                      && eff_addr <= mdp_pkg::SRAM_TOP;
    wire logic [3:0] data_mc = is_x ? {1'b0, stretch} + mdp_pkg::MC_ONE
                                    : mdp_pkg::CODE_DATA_MC;
    wire logic last_clk = ck == mdp_pkg::MC_LAST;
    wire logic held = wait_enable && !p4_0_in;
    wire logic ext_done = st == S_DATA && last_clk
                       && mc == mdp_pkg::MC_ONE && !held;
    wire logic int_done = st == S_INT && last_clk;
    wire logic cur_wr = cur.kind == mdp_pkg::MDP_XDATA_WR;
    wire logic cur_code = cur.kind == mdp_pkg::MDP_FETCH
                       || cur.kind == mdp_pkg::MDP_CODE_RD;
    wire logic [mdp_pkg::SRAM_AW-1:0] sidx = cur.addr[mdp_pkg::SRAM_AW-1:0];

    always_comb begin
        next_st = st;
        unique case (st)
            S_IDLE: if (take) next_st = hit_int ? S_INT : S_ADDR;
            S_ADDR: if (last_clk) next_st = S_DATA;
            S_DATA: if (ext_done) next_st = S_IDLE;
            S_INT:  if (last_clk) next_st = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st  <= S_IDLE;
            ck  <= 2'h0;
            mc  <= 4'h0;
            cur <= '0;
        end else begin
            st <= next_st;
            if (take) begin
                ck  <= 2'h0;
                mc  <= data_mc;
                cur <= '{req.kind, req.use_ptr, eff_addr, req.wdata};
            end else if (!(st == S_DATA && last_clk && held)) begin
                ck <= ck + 2'h1;
                if (st == S_DATA && last_clk) begin
                    mc <= mc - mdp_pkg::MC_ONE;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (int_done && cur_wr) begin
            sram[sidx] <= cur.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            busy       <= 1'b0;
            resp_valid <= 1'b0;
            resp_rdata <= mdp_pkg::BYTE_ZERO;
        end else begin
            busy       <= next_st != S_IDLE;
            resp_valid <= ext_done || int_done;
            if (ext_done) begin
                resp_rdata <= p0_in;
            end else if (int_done) begin
                resp_rdata <= sram[sidx];
            end
        end
    end

    // ==========================================================
    // Pin drive
    wire logic bus = st == S_ADDR || st == S_DATA;
    wire logic in_data = st == S_DATA;
    wire logic drv_data = in_data && cur_wr;
    wire logic [7:0] next_p0_out = st == S_ADDR ? cur.addr[7:0]
                                 : drv_data ? cur.wdata : p0_latch;
    wire logic [7:0] next_p0_oe = (st == S_ADDR || drv_data) ? mdp_pkg::BYTE_ONES
                                : in_data ? mdp_pkg::BYTE_ZERO
                                : ~p0_latch;
    wire logic [7:0] next_p2_out = bus ? cur.addr[15:8] : p2_latch;
    wire logic [7:0] next_p2_oe = bus ? mdp_pkg::BYTE_ONES : ~p2_latch;
    wire logic next_ale = st == S_ADDR && ck < mdp_pkg::ALE_CLKS;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            p0_out    <= mdp_pkg::PORT_RST;
            p0_oe     <= mdp_pkg::BYTE_ZERO;
            p0_strong <= 1'b0;
            p2_out    <= mdp_pkg::PORT_RST;
            p2_oe     <= mdp_pkg::BYTE_ZERO;
            ale       <= 1'b0;
            psen_n    <= 1'b1;
            rd_n      <= 1'b1;
            wr_n      <= 1'b1;
            p4_0_out  <= 1'b1;
            p4_0_oe   <= 1'b0;
        end else begin
            p0_out    <= next_p0_out;
            p0_oe     <= next_p0_oe;
            p0_strong <= bus;
            p2_out    <= next_p2_out;
            p2_oe     <= next_p2_oe;
            ale       <= next_ale;
            psen_n    <= !(in_data && cur_code);
            rd_n      <= !(in_data && cur.kind == mdp_pkg::MDP_XDATA_RD);
            wr_n      <= !drv_data;
            p4_0_out  <= 1'b1;
            p4_0_oe   <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    reset_clear_a: assert property (
        $past(sys_rst) |-> !onchip_sram_enable)
        else $error("sram enable not cleared by reset");
    dec_ptr_a: assert property (
        ptr_dec && !pointer_select && !sfr_we
        |=> data_pointer[0] == $past(data_pointer[0]) - 16'h0001)
        else $error("pointer decrement wrong");
    sel_ptr_a: assert property (
        take && req.use_ptr && pointer_select
        |=> cur.addr == $past(data_pointer[1]))
        else $error("second pointer not used");
    int_route_a: assert property (
        take && hit_int |=> st == S_INT ##4 resp_valid)
        else $error("internal access misrouted");
    ext_route_a: assert property (
        take && is_x && eff_addr > mdp_pkg::SRAM_TOP |=> st == S_ADDR)
        else $error("high access not external");
    int_quiet_a: assert property (
        st == S_INT |=> rd_n && wr_n && psen_n && !ale && !p0_strong)
        else $error("bus active on internal access");
    len_min_a: assert property (
        take && !hit_int && is_x && stretch == 3'h0 && !wait_enable
        |=> !resp_valid [*8] ##1 resp_valid)
        else $error("two cycle access length wrong");
    len_max_a: assert property (
        take && !hit_int && is_x && stretch == 3'h7 && !wait_enable
        |-> ##37 resp_valid)
        else $error("nine cycle access length wrong");
    wait_in_a: assert property (
        wait_enable |=> !p4_0_oe)
        else $error("wait pin driven");
    p2_addr_a: assert property (
        st == S_ADDR |=> p2_oe == mdp_pkg::BYTE_ONES
                         && p2_out == cur.addr[15:8])
        else $error("port 2 address missing");

endmodule

//--- tb/mdp_ext_ram.sv
`timescale 1ns/10ps
module mdp_ext_ram (
    input  wire logic       mclk,
    input  wire logic       ale,
    input  wire logic       psen_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [7:0] p0_out,
    input  wire logic [7:0] p0_oe,
    input  wire logic [7:0] p2_out,
    input  wire logic       slow,
    output logic      [7:0] p0_in,
    output logic            wait_n
);
    logic [7:0]  mem [0:65535];
    logic [15:0] addr_lat;
    logic [7:0]  last = 8'h5A;
    logic [2:0]  cnt = 3'h0;
    wire         strb = !rd_n || !wr_n || !psen_n;
    wire         drv  = !rd_n || !psen_n;
    wire  [7:0]  dout = mem[addr_lat];

    // Released lines show the inverse of the last level, no keeper
    always @(posedge mclk) begin
        last <= p0_in;
        if (ale) begin
            addr_lat <= {p2_out, p0_out};
        end
        if (!wr_n) begin
            mem[addr_lat] <= p0_out;
        end
        cnt <= strb ? ((cnt == 3'h7) ? cnt : cnt + 3'h1) : 3'h0;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            p0_in[i] = p0_oe[i] ? p0_out[i] : (drv ? dout[i] : ~last[i]);
        end
    end

    // Slow device holds the wait line low early in each strobe
    assign wait_n = !(slow && strb && cnt < 3'h3);
endmodule

//--- tb/external_data_move_data_memory_path_tb.sv
`timescale 1ns/10ps
module external_data_move_data_memory_path_tb;
    logic mclk = 0, sys_rst, req_valid, op_valid, sfr_wr, sfr_indirect;
    logic wait_enable, slow, busy, resp_valid, p0_strong, ale, psen_n;
    logic rd_n, wr_n, p4_0_in, p4_0_out, p4_0_oe, onchip_sram_enable;
    mdp_pkg::mdp_req_t req;
    logic [7:0] resp_rdata, opcode, sfr_addr, sfr_wdata, sfr_rdata, p0_in;
    logic [7:0] p0_out, p0_oe, p2_out, p2_oe, cap_p2, cap_oe, cap_p0oe;
    logic [2:0] stretch;
    logic       cap_st, cap_bz;
    int         failures = 0, n_tests = 0, lat, bus_act = 0, b;

    always #2 mclk = ~mclk;

    mdp_external_data_move_path i_mdp_external_data_move_path (
        .mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
        .busy(busy), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
        .op_valid(op_valid), .opcode(opcode), .sfr_wr(sfr_wr),
        .sfr_indirect(sfr_indirect), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .stretch(stretch),
        .wait_enable(wait_enable), .p0_in(p0_in), .p0_out(p0_out),
        .p0_oe(p0_oe), .p0_strong(p0_strong), .p2_out(p2_out),
        .p2_oe(p2_oe), .ale(ale), .psen_n(psen_n), .rd_n(rd_n), .wr_n(wr_n),
        .p4_0_in(p4_0_in), .p4_0_out(p4_0_out), .p4_0_oe(p4_0_oe),
        .onchip_sram_enable(onchip_sram_enable));
    mdp_ext_ram i_mdp_ext_ram (.mclk(mclk), .ale(ale), .psen_n(psen_n),
        .rd_n(rd_n), .wr_n(wr_n), .p0_out(p0_out), .p0_oe(p0_oe),
        .p2_out(p2_out), .slow(slow), .p0_in(p0_in), .wait_n(p4_0_in));

    // ======================================================
    // Bus watch
    always @(posedge mclk) begin
        if (!rd_n || !wr_n || !psen_n || ale || p0_strong || p2_oe != 0)
            bus_act++;
        if (ale) begin
            cap_p2 <= p2_out;
            cap_oe <= p2_oe;
            cap_st <= p0_strong;
            cap_bz <= busy;
        end
        if (!rd_n) begin
            cap_p0oe <= p0_oe;
        end
    end

    // ======================================================
    // Tasks
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string m);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic acc(input mdp_pkg::mdp_kind_t k, input logic [15:0] a,
                       input logic [7:0] d, input logic up);
        @(posedge mclk);
        req_valid <= 1'b1;
        req       <= '{kind: k, use_ptr: up, addr: a, wdata: d};
        @(posedge mclk);
        req_valid <= 1'b0;
        // Counts up to the edge at which resp_valid is sampled high
        lat = 1;
        do begin
            @(posedge mclk);
            #1;
            lat++;
        end while (resp_valid !== 1'b1 && lat < 100);
    endtask

    task automatic sfr_w(input logic [7:0] a, input logic [7:0] d,
                         input logic ind);
        @(posedge mclk);
        sfr_wr       <= 1'b1;
        sfr_addr     <= a;
        sfr_wdata    <= d;
        sfr_indirect <= ind;
        @(posedge mclk);
        sfr_wr <= 1'b0;
        #1;
    endtask

    task automatic sfr_rd(input logic [7:0] a, input logic ind,
                          input logic [7:0] e);
        @(posedge mclk);
        sfr_addr     <= a;
        sfr_indirect <= ind;
        repeat (2) @(posedge mclk);
        #1;
        chk(sfr_rdata, e, "sfr read");
    endtask

    task automatic dec_ptr;
        @(posedge mclk);
        op_valid <= 1'b1;
        opcode   <= mdp_pkg::OP_PTR_DEC;
        @(posedge mclk);
        op_valid <= 1'b0;
    endtask

    // ======================================================
    // Tests
    initial begin
        sys_rst = 1; req_valid = 0; op_valid = 0; opcode = 8'h00;
        req = '0; sfr_wr = 0; sfr_indirect = 0; sfr_addr = 8'h00;
        sfr_wdata = 8'h00; stretch = 3'h0; wait_enable = 0; slow = 0;
        i_mdp_ext_ram.mem[16'h03FF] = 8'h3C;
        i_mdp_ext_ram.mem[16'h0400] = 8'h5E;
        for (int s = 0; s < 8; s++) begin
            i_mdp_ext_ram.mem[16'h8000 + s] = 8'h40 + 8'(s);
        end
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        #1;
        chk(onchip_sram_enable, 0, "en rst");
        chk(p2_oe, 0, "p2 oe rst");
        acc(mdp_pkg::MDP_XDATA_WR, 16'h0010, 8'h77, 0);
        chk(lat, 9, "wr lat");
        chk(i_mdp_ext_ram.mem[16'h0010], 8'h77, "wr data");
        chk({cap_oe, 7'h00, cap_st}, 16'hFF01, "bus drive");
        chk({cap_bz, busy}, 2'b10, "busy");
        acc(mdp_pkg::MDP_XDATA_RD, 16'h03FF, 8'h00, 0);
        chk(resp_rdata, 8'h3C, "rd ext low");
        chk({cap_p2, cap_p0oe}, 16'h0300, "rd pins");
        for (int s = 0; s < 8; s += 7) begin
            stretch <= 3'(s);
            acc(mdp_pkg::MDP_XDATA_RD, 16'h8000 + 16'(s), 8'h00, 0);
            chk(lat, 16'(1 + 4 * (s + 2)), "stretch lat");
            chk(resp_rdata, 8'h40 + 8'(s), "stretch data");
        end
        stretch <= 3'h0;
        sfr_w(mdp_pkg::SFR_PWR_MGMT, 8'h01, 0);
        chk(onchip_sram_enable, 1, "en set");
        b = bus_act;
        acc(mdp_pkg::MDP_XDATA_WR, 16'h03FF, 8'hA5, 0);
        chk(lat, 5, "int lat");
        acc(mdp_pkg::MDP_XDATA_RD, 16'h03FF, 8'h00, 0);
        chk(resp_rdata, 8'hA5, "int data");
        chk(bus_act - b, 0, "int quiet");
        chk(i_mdp_ext_ram.mem[16'h03FF], 8'h3C, "ext kept");
        acc(mdp_pkg::MDP_XDATA_RD, 16'h0400, 8'h00, 0);
        chk({resp_rdata, 4'(lat)}, {8'h5E, 4'h9}, "above top");
        acc(mdp_pkg::MDP_FETCH, 16'h0010, 8'h00, 0);
        chk({resp_rdata, psen_n}, {8'h77, 1'b0}, "fetch");
        acc(mdp_pkg::MDP_CODE_RD, 16'h0010, 8'h00, 0);
        chk(resp_rdata, 8'h77, "code read");
        sfr_w(mdp_pkg::SFR_PTR0_L, 8'h00, 0);
        sfr_w(mdp_pkg::SFR_PTR0_H, 8'h12, 0);
        sfr_w(mdp_pkg::SFR_PTR1_L, 8'h05, 0);
        sfr_w(mdp_pkg::SFR_PTR1_H, 8'h40, 0);
        sfr_w(mdp_pkg::SFR_PTR0_L, 8'h99, 1);
        sfr_w(mdp_pkg::SFR_PTR_SEL, 8'h01, 0);
        dec_ptr();
        sfr_rd(mdp_pkg::SFR_PTR1_L, 0, 8'h04);
        sfr_rd(mdp_pkg::SFR_PTR1_H, 0, 8'h40);
        sfr_rd(mdp_pkg::SFR_PTR0_L, 1, 8'hFF);
        sfr_w(mdp_pkg::SFR_PTR_SEL, 8'h00, 0);
        dec_ptr();
        sfr_rd(mdp_pkg::SFR_PTR0_L, 0, 8'hFF);
        sfr_rd(mdp_pkg::SFR_PTR0_H, 0, 8'h11);
        acc(mdp_pkg::MDP_XDATA_WR, 16'h0000, 8'hC3, 1);
        chk(i_mdp_ext_ram.mem[16'h11FF], 8'hC3, "ptr move");
        sfr_w(mdp_pkg::SFR_PTR_SEL, 8'h01, 0);
        acc(mdp_pkg::MDP_XDATA_WR, 16'h0000, 8'h3A, 1);
        chk(i_mdp_ext_ram.mem[16'h4004], 8'h3A, "ptr1 move");
        sfr_w(mdp_pkg::SFR_PORT0, 8'h0F, 0);
        @(posedge mclk);
        #1;
        chk({p0_oe, 7'h00, p0_strong}, 16'hF000, "open drain");
        wait_enable <= 1'b1;
        slow        <= 1'b1;
        acc(mdp_pkg::MDP_XDATA_RD, 16'h0400, 8'h00, 0);
        chk(lat > 9 && lat <= 20, 1, "wait lat");
        chk({resp_rdata, p4_0_oe, p4_0_out}, {8'h5E, 2'b01}, "wait pin");
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        #1;
        chk(onchip_sram_enable, 0, "en rst2");
        summarize();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        summarize();
    end
endmodule
